// ==== hw/dg_gate.sv ====
// Purpose: Gate pin steering onto colour or secondary display
// Assumes: Gate pin asynchronous to sys_clk; APB master per protocol
// Notes:   Zero-wait APB slave; unmapped reads return zero
//
// Notes on behaviour
// - Select 0: pin gates colour display
// - Secondary lit at its nibble when pin high
// - Colour lit at its nibbles when pin high
// - Nothing lit means full shutdown
// - Unselected display ignores the gate pin
// - Pin acts directly, no further bus access
// - Colour duty is code over fifteen
// - Secondary code zero means off
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dg_gate (
  input  wire logic        sys_clk,           // 100 MHz clock
  input  wire logic        rst_b,             // Async reset, low
  input  wire logic        display_gate_pin,  // Async gate pin
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  output logic             red_drive,         // Red PWM
  output logic             green_drive,       // Green PWM
  output logic             blue_drive,        // Blue PWM
  output logic             secondary_on,      // Secondary lit
  output logic       [3:0] secondary_level,   // Secondary level
  output logic             main_on,           // Main lit
  output logic       [3:0] main_level,        // Main level
  output logic             shutdown           // Full shutdown
);
  // -------------------------------------------------------------
  // Gate pin synchroniser
  // -------------------------------------------------------------
  // Reset low keeps gated enables off until the pin is seen
  logic gate_meta_r;
  logic gate_sync_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_meta_r <= 1'b0;
      gate_sync_r <= 1'b0;
    end else begin
      gate_meta_r <= display_gate_pin;
      gate_sync_r <= gate_meta_r;
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic       gate_target_select_r;
  logic [3:0] main_level_nibble_r;
  logic [3:0] red_level_nibble_r;
  logic [3:0] green_level_nibble_r;
  logic [3:0] blue_level_nibble_r;
  logic [3:0] secondary_level_nibble_r;
  logic       wr_en;
  logic       rd_en;
  logic       hit;

  // Writes land only on the edge that completes the access phase
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit   = (paddr == dg_pkg::OFS_CTRL) ||
                 (paddr == dg_pkg::OFS_LEVELS) ||
                 (paddr == dg_pkg::OFS_STATUS);

  // Host writes select and levels before relying on the pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_target_select_r <= 1'b0;
      main_level_nibble_r  <= dg_pkg::LEVEL_OFF;
    end else if (wr_en && paddr == dg_pkg::OFS_CTRL) begin
      gate_target_select_r <= pwdata[dg_pkg::CTRL_SEL_BIT];
      main_level_nibble_r  <=
        pwdata[dg_pkg::CTRL_MAIN_LSB +: dg_pkg::NIB_W];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      red_level_nibble_r       <= dg_pkg::LEVEL_OFF;
      green_level_nibble_r     <= dg_pkg::LEVEL_OFF;
      blue_level_nibble_r      <= dg_pkg::LEVEL_OFF;
      secondary_level_nibble_r <= dg_pkg::LEVEL_OFF;
    end else if (wr_en && paddr == dg_pkg::OFS_LEVELS) begin
      red_level_nibble_r       <=
        pwdata[dg_pkg::LVL_RED_LSB +: dg_pkg::NIB_W];
      green_level_nibble_r     <=
        pwdata[dg_pkg::LVL_GRN_LSB +: dg_pkg::NIB_W];
      blue_level_nibble_r      <=
        pwdata[dg_pkg::LVL_BLU_LSB +: dg_pkg::NIB_W];
      secondary_level_nibble_r <=
        pwdata[dg_pkg::LVL_SEC_LSB +: dg_pkg::NIB_W];
    end
  end

  // -------------------------------------------------------------
  // Display enables
  // -------------------------------------------------------------
  logic colour_en;
  logic sec_en;
  logic colour_prog;
  logic sec_prog;
  logic main_prog;

  assign colour_prog = (red_level_nibble_r   != dg_pkg::LEVEL_OFF) ||
                       (green_level_nibble_r != dg_pkg::LEVEL_OFF) ||
                       (blue_level_nibble_r  != dg_pkg::LEVEL_OFF);
  assign sec_prog    = secondary_level_nibble_r != dg_pkg::LEVEL_OFF;
  assign main_prog   = main_level_nibble_r != dg_pkg::LEVEL_OFF;

  // Pin gates only the selected display, acting without bus traffic
  assign colour_en = colour_prog &&
                     (gate_target_select_r || gate_sync_r);
  assign sec_en    = sec_prog &&
                     (!gate_target_select_r || gate_sync_r);

  // -------------------------------------------------------------
  // Colour PWM, shared phase 0..14
  // -------------------------------------------------------------
  logic [3:0] phase_r;
  // Fifteen-clock period, so code fifteen never drops low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 4'h0;
    end else if (phase_r == dg_pkg::PWM_TOP) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end

  dg_pwm u_red (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .phase   (phase_r),
    .code    (red_level_nibble_r),
    .enable  (colour_en),
    .pwm_out (red_drive)
  );
  dg_pwm u_green (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .phase   (phase_r),
    .code    (green_level_nibble_r),
    .enable  (colour_en),
    .pwm_out (green_drive)
  );
  dg_pwm u_blue (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .phase   (phase_r),
    .code    (blue_level_nibble_r),
    .enable  (colour_en),
    .pwm_out (blue_drive)
  );

  // -------------------------------------------------------------
  // White displays and shutdown
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      secondary_on    <= 1'b0;
      secondary_level <= dg_pkg::LEVEL_OFF;
      main_on         <= 1'b0;
      main_level      <= dg_pkg::LEVEL_OFF;
      shutdown        <= 1'b1;
    end else begin
      secondary_on    <= sec_en;
      secondary_level <= sec_en ? secondary_level_nibble_r
                                : dg_pkg::LEVEL_OFF;
      main_on         <= main_prog;
      main_level      <= main_level_nibble_r;
      shutdown        <= !(colour_en || sec_en || main_prog);
    end
  end

  // -------------------------------------------------------------
  // APB read side
  // -------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = dg_pkg::DATA_ZERO;
    if (paddr == dg_pkg::OFS_CTRL) begin
      rd_nxt[dg_pkg::CTRL_SEL_BIT] = gate_target_select_r;
      rd_nxt[dg_pkg::CTRL_MAIN_LSB +: dg_pkg::NIB_W] = main_level_nibble_r;
    end else if (paddr == dg_pkg::OFS_LEVELS) begin
      rd_nxt[dg_pkg::LVL_RED_LSB +: dg_pkg::NIB_W] = red_level_nibble_r;
      rd_nxt[dg_pkg::LVL_GRN_LSB +: dg_pkg::NIB_W] = green_level_nibble_r;
      rd_nxt[dg_pkg::LVL_BLU_LSB +: dg_pkg::NIB_W] = blue_level_nibble_r;
      rd_nxt[dg_pkg::LVL_SEC_LSB +: dg_pkg::NIB_W] =
        secondary_level_nibble_r;
    end else if (paddr == dg_pkg::OFS_STATUS) begin
      rd_nxt[dg_pkg::ST_GATE_BIT]   = gate_sync_r;
      rd_nxt[dg_pkg::ST_COLOUR_BIT] = colour_en;
      rd_nxt[dg_pkg::ST_SEC_BIT]    = sec_en;
      rd_nxt[dg_pkg::ST_MAIN_BIT]   = main_prog;
      rd_nxt[dg_pkg::ST_SHDN_BIT]   = shutdown;
    end
  end

  // Zero-wait slave: pready held high so outputs stay registered
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= dg_pkg::DATA_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && !hit;
      prdata  <= rd_en ? rd_nxt : prdata;
    end
  end
endmodule

// ==== hw/dg_pkg.sv ====
// Purpose: Shared constants for the display enable gating block
// Assumes: 100 MHz sys_clk, APB register access
// Notes:   Byte offsets of the word-aligned registers
package dg_pkg;
  localparam int unsigned        NIB_W          = 4;
  localparam int unsigned        ADDR_W         = 8;
  // -------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------
  localparam logic [7:0]         OFS_CTRL       = 8'h00;
  localparam logic [7:0]         OFS_LEVELS     = 8'h04;
  localparam logic [7:0]         OFS_STATUS     = 8'h08;
  // CTRL fields
  localparam int unsigned        CTRL_SEL_BIT   = 0;
  localparam int unsigned        CTRL_MAIN_LSB  = 4;
  // LEVELS fields
  localparam int unsigned        LVL_RED_LSB    = 0;
  localparam int unsigned        LVL_GRN_LSB    = 4;
  localparam int unsigned        LVL_BLU_LSB    = 8;
  localparam int unsigned        LVL_SEC_LSB    = 12;
  // STATUS fields
  localparam int unsigned        ST_GATE_BIT    = 0;
  localparam int unsigned        ST_COLOUR_BIT  = 1;
  localparam int unsigned        ST_SEC_BIT     = 2;
  localparam int unsigned        ST_MAIN_BIT    = 3;
  localparam int unsigned        ST_SHDN_BIT    = 4;
  // -------------------------------------------------------------
  // Resets and PWM
  // -------------------------------------------------------------
  localparam logic [3:0]         LEVEL_OFF      = 4'h0;
  localparam logic [3:0]         PWM_TOP        = 4'he;
  localparam logic [31:0]        DATA_ZERO      = 32'h0000_0000;
endpackage

// ==== hw/dg_pwm.sv ====
// Purpose: Linear duty PWM channel, duty code/15
// Assumes: Shared phase counter runs 0..14
// Notes:   Code 0 never high, code 15 always high
`timescale 1ns/1ps
module dg_pwm (
  input  wire logic       sys_clk,  // Clock
  input  wire logic       rst_b,    // Async reset, low
  input  wire logic [3:0] phase,    // Shared phase 0..14
  input  wire logic [3:0] code,     // Duty code
  input  wire logic       enable,   // Channel enable
  output logic            pwm_out   // Registered output
);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= enable && (phase < code);
    end
  end
endmodule

// ==== testbench/dg_gate_checker.sv ====
// Purpose: Port-level checks for the display gate block
// Assumes: Config is tracked from completed APB writes
// Notes:   Quiet count hides settling right after a write
`timescale 1ns/1ps
module dg_gate_checker (
  input wire logic        sys_clk,          // Clock
  input wire logic        rst_b,            // Reset, low
  input wire logic        display_gate_pin, // Gate pin
  input wire logic        psel,             // APB select
  input wire logic        penable,          // APB enable
  input wire logic        pwrite,           // APB direction
  input wire logic [7:0]  paddr,            // APB address
  input wire logic [31:0] pwdata,           // APB write data
  input wire logic        pready,           // APB ready
  input wire logic        pslverr,          // APB error
  input wire logic        red_drive,        // Red PWM
  input wire logic        green_drive,      // Green PWM
  input wire logic        blue_drive,       // Blue PWM
  input wire logic        secondary_on,     // Secondary lit
  input wire logic [3:0]  secondary_level,  // Secondary level
  input wire logic        main_on,          // Main lit
  input wire logic        shutdown          // Full shutdown
);
  logic       sel_r;
  logic [3:0] sec_r;
  logic [2:0] quiet_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r   <= 1'b0;
      sec_r   <= 4'h0;
      quiet_r <= 3'h0;
    end else if (psel && penable && pready && pwrite) begin
      quiet_r <= 3'h0;
      if (paddr == dg_pkg::OFS_CTRL) sel_r <= pwdata[0];
      if (paddr == dg_pkg::OFS_LEVELS) sec_r <= pwdata[15:12];
    end else if (quiet_r != 3'h4) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence settled;
    quiet_r == 3'h4;
  endsequence
  chk_ready_up: assert property ($past(rst_b) |-> pready)
    else $error("ready low outside reset");
  chk_slave_err: assert property (apb_setup |=> pslverr ==
    !($past(paddr) inside {8'h00, 8'h04, 8'h08}))
    else $error("error flag wrong for address");
  chk_sec_gated: assert property (
    settled ##0 (sel_r && sec_r != 4'h0)
    |-> secondary_on == $past(display_gate_pin, 3))
    else $error("secondary does not follow gate pin");
  chk_sec_level: assert property (settled ##0 secondary_on
    |-> secondary_level == sec_r) else $error("secondary level wrong");
  chk_sec_zero: assert property (
    !secondary_on |-> secondary_level == 4'h0)
    else $error("secondary level while off");
  chk_sec_ungated: assert property (settled ##0 !sel_r
    |-> secondary_on == (sec_r != 4'h0)) else $error("ungated display wrong");
  chk_rgb_off: assert property (settled ##0 (!sel_r
    && !$past(display_gate_pin, 3) && !$past(display_gate_pin, 4))
    |-> !(red_drive || green_drive || blue_drive))
    else $error("colour lit with gate low");
  chk_lit_awake: assert property (
    (secondary_on || main_on) |-> !shutdown)
    else $error("shutdown while a display is lit");
endmodule
bind dg_gate dg_gate_checker dg_gate_checker_inst (.*);

// ==== testbench/dg_host_model.sv ====
// Purpose: Host side: APB master and gate pin driver
// Assumes: Slave ready may come late; bounded wait
// Notes:   Answers taken at the rising edge that completes
`timescale 1ns/1ps
module dg_host_model (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        pready,           // APB ready
  input  wire logic [31:0] prdata,           // APB read data
  output logic             psel,             // APB select
  output logic             penable,          // APB enable
  output logic             pwrite,           // APB direction
  output logic      [7:0]  paddr,            // APB address
  output logic      [31:0] pwdata,           // APB write data
  output logic             display_gate_pin  // Gate pin
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    display_gate_pin = 1'b1;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    logic rdy;
    rdy = 1'b0;
    q = 32'h0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !rdy; n++) begin
      // Slave flops still show their pre-edge value here
      @(posedge sys_clk);
      if (pready) begin
        rdy = 1'b1;
        q = prdata;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps the next call out of this time step
    @(posedge sys_clk);
    if (!rdy) begin
      dg_gate_tb_top.miscompares++;
      dg_gate_tb_top.final_report();
    end
  endtask
  task automatic set_gate(input logic v);
    display_gate_pin <= v;
  endtask
endmodule

// ==== testbench/dg_gate_tb_top.sv ====
// Purpose: Self-checking bench for the display gate block
// Assumes: Host model drives APB and the gate pin
// Notes:   Pin changes given six cycles to reach outputs
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module dg_gate_tb_top;
  logic sys_clk, rst_b, display_gate_pin, psel, penable, pwrite, pready;
  logic pslverr, red_drive, green_drive, blue_drive, secondary_on;
  logic main_on, shutdown;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] secondary_level, main_level;
  logic [4:0] r, g, b;
  int miscompares = 0;
  int checks = 0;
  dg_gate dg_gate_inst (.*);
  dg_host_model dg_host_model_inst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dg_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    dg_host_model_inst.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic pin(input logic v);
    dg_host_model_inst.set_gate(v);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic duty();
    r = 5'h0;
    g = 5'h0;
    b = 5'h0;
    repeat (15) begin
      @(negedge sys_clk);
      r = r + {4'h0, red_drive};
      g = g + {4'h0, green_drive};
      b = b + {4'h0, blue_drive};
    end
    @(posedge sys_clk);
  endtask
  task automatic test_regs();
    rd(dg_pkg::OFS_CTRL);
    `CHK(q, dg_pkg::DATA_ZERO)
    wr(dg_pkg::OFS_CTRL, 32'h50);
    rd(dg_pkg::OFS_CTRL);
    `CHK(q, 32'h50)
    pin(1'b0);
    `CHK({main_on, main_level, shutdown}, 6'h2a)
    rd(8'h0c);
    `CHK(q, dg_pkg::DATA_ZERO)
    wr(dg_pkg::OFS_CTRL, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_sec_gate();
    wr(dg_pkg::OFS_LEVELS, 32'h9000);
    wr(dg_pkg::OFS_CTRL, 32'h1);
    pin(1'b0);
    `CHK({secondary_on, secondary_level, shutdown}, 6'h01)
    pin(1'b1);
    `CHK({secondary_on, secondary_level, shutdown}, 6'h32)
    wr(dg_pkg::OFS_LEVELS, 32'h900f);
    pin(1'b0);
    `CHK({secondary_on, red_drive, shutdown}, 3'h2)
    $display("test_sec_gate done");
  endtask
  task automatic test_rgb_gate();
    wr(dg_pkg::OFS_LEVELS, 32'h0005);
    wr(dg_pkg::OFS_CTRL, 32'h0);
    pin(1'b0);
    duty();
    `CHK({r, shutdown}, 6'h01)
    pin(1'b1);
    duty();
    `CHK({r, g, b}, 15'h1400)
    wr(dg_pkg::OFS_LEVELS, 32'h30f0);
    duty();
    `CHK({r, g, b}, 15'h01e0)
    wr(dg_pkg::OFS_LEVELS, 32'h3700);
    duty();
    `CHK({r, g, b}, 15'h0007)
    pin(1'b0);
    `CHK({secondary_on, secondary_level}, 5'h13)
    $display("test_rgb_gate done");
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    test_regs();
    test_sec_gate();
    test_rgb_gate();
    final_report();
  end
endmodule
